// File: hw/uart_stat_defs.vh
/*
  Register offsets, field positions, reset values and sizing for the UART
  line and modem status block.
  Assumes an 8-bit register port with a 3-bit word address.
*/
`ifndef UART_STAT_DEFS_VH
`define UART_STAT_DEFS_VH

// ----------------------------------------------------------------
// register offsets (word address)
// ----------------------------------------------------------------
`define OFS_RX_DATA 3'h0
`define OFS_FIFO_CTRL 3'h1
`define OFS_ENH_FEATURE 3'h2
`define OFS_INT_STATUS 3'h3
`define OFS_MODEM_CTRL 3'h4
`define OFS_LINE_STATUS 3'h5
`define OFS_MODEM_STATUS 3'h6
`define OFS_INT_MASK 3'h7

// ----------------------------------------------------------------
// line status fields
// ----------------------------------------------------------------
`define LS_RX_READY 0
`define LS_OVERRUN 1
`define LS_PARITY 2

// ----------------------------------------------------------------
// modem status fields
// ----------------------------------------------------------------
`define MS_CTS_CHG 0
`define MS_DSR_CHG 1
`define MS_RING_RISE 2
`define MS_CARRIER_CHG 3
`define MS_CTS 4
`define MS_DSR 5
`define MS_RING 6
`define MS_CARRIER 7

// ----------------------------------------------------------------
// modem control fields
// ----------------------------------------------------------------
`define MC_DTR 0
`define MC_RTS 1
`define MC_USER_OUTPUT_ONE 2
`define MC_USER_OUTPUT_TWO 3
`define MC_LOOP 4

// ----------------------------------------------------------------
// other control fields
// ----------------------------------------------------------------
`define FC_FIFO_EN 0
`define EF_AUTO_CTS 7

// ----------------------------------------------------------------
// interrupt status fields
// ----------------------------------------------------------------
`define IS_MODEM 0
`define IS_OVERRUN 1
`define IS_PARITY 2
`define IS_RX_DATA 3

// ----------------------------------------------------------------
// reset values and sizing
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_PINS 4'hF
`define RX_FIFO_DEPTH 16
`define RX_FIFO_AW 4

`endif

// File: hw/rx_fifo.v
/*
  Receive FIFO: stores each character with its parity-error bit.
  Assumes the caller never pushes when full nor pops when empty.
*/
`timescale 1ns/1ps
module rx_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
)(
  input wire clk,
  input wire rst_n,
  input wire push,
  input wire [WIDTH-1:0] push_data,
  input wire pop,
  output wire [WIDTH-1:0] head_data,
  output wire empty,
  output wire full
);
  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;

  assign head_data = mem[rd_ptr_reg];
  assign empty = (count_reg == {(AW+1){1'b0}});
  assign full = (count_reg == DEPTH[AW:0]);

  // no reset on the array: contents are only read once counted in
  always @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // rx_fifo

// File: hw/uart_line_modem_status.v
/*
  Line status and modem status logic of a 16-byte-FIFO UART, with the
  receive FIFO, modem-input change detection, loop-back substitution,
  automatic CTS transmit gating and a masked interrupt.
  Assumes a receiver on ref_clk that pulses rx_char_valid per character,
  a transmitter that asks tx_start_req before each character, and modem
  pins that are asynchronous to ref_clk.
*/
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "uart_stat_defs.vh"
module uart_line_modem_status #(
  parameter DEPTH = `RX_FIFO_DEPTH,
  parameter AW = `RX_FIFO_AW
)(
  input wire ref_clk,
  input wire arst_n,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  input wire rx_char_valid,
  input wire [7:0] rx_char_data,
  input wire rx_char_parity_err,
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire dcd_n,
  output wire rts_n,
  output wire dtr_n,
  output wire user_output_one_n,
  output wire user_output_two_n,
  input wire tx_start_req,
  output wire tx_start_grant,
  output wire tx_halt,
  output wire modem_irq,
  output wire irq
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // sticky flag update: a set in the clearing cycle wins
  function [7:0] sticky;
    input [7:0] cur;
    input [7:0] clr;
    input [7:0] set;
    begin
      sticky = (cur & ~clr) | set;
    end
  endfunction

  function hit;
    input [2:0] addr;
    input [2:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg [7:0] fifo_ctrl_reg;
  reg [7:0] modem_control_reg;
  reg [7:0] enhanced_feature_control_reg;
  reg [7:0] int_status_reg;
  reg [7:0] int_status_next;
  reg [7:0] int_mask_reg;
  reg [7:0] rdata_reg;
  reg [7:0] rdata_next;
  reg [7:0] rx_shift_reg;
  reg overrun_reg;
  reg overrun_next;
  reg [3:0] pin_meta_reg;
  reg [3:0] pin_sync_reg;
  reg [3:0] prev_active_reg;
  reg [3:0] change_reg;
  reg [3:0] change_next;
  wire [3:0] pin_active;
  wire [3:0] loop_active;
  wire [3:0] modem_active;
  wire [3:0] change_set;
  wire [8:0] head_data;
  wire fifo_empty;
  wire fifo_full;
  wire fifo_mode;
  wire loop_mode;
  wire auto_cts_enable;
  wire rx_full;
  wire rx_push;
  wire rx_pop;
  wire rx_over;
  wire rd_line_status;
  wire rd_modem_status;
  wire [7:0] line_status;
  wire [7:0] modem_status;
  wire [7:0] int_set;
  wire [7:0] int_clr;

  // ----------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------
  assign fifo_mode = fifo_ctrl_reg[`FC_FIFO_EN];
  assign loop_mode = modem_control_reg[`MC_LOOP];
  assign auto_cts_enable = enhanced_feature_control_reg[`EF_AUTO_CTS];
  assign rd_line_status = reg_rd && hit(reg_addr, `OFS_LINE_STATUS);
  assign rd_modem_status = reg_rd && hit(reg_addr, `OFS_MODEM_STATUS);

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  // without FIFO mode only one slot at a time acts as holding register
  assign rx_full = fifo_mode ? fifo_full : !fifo_empty;
  assign rx_over = rx_char_valid && rx_full;
  assign rx_push = rx_char_valid && !rx_full;
  assign rx_pop = reg_rd && hit(reg_addr, `OFS_RX_DATA) && !fifo_empty;

  rx_fifo #(
    .WIDTH(9),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_rx_fifo (
    .clk(ref_clk),
    .rst_n(arst_n),
    .push(rx_push),
    .push_data({rx_char_parity_err, rx_char_data}),
    .pop(rx_pop),
    .head_data(head_data),
    .empty(fifo_empty),
    .full(fifo_full)
  );

  always @*
  begin
    overrun_next = overrun_reg;
    if (rd_line_status)
    begin
      overrun_next = 1'b0;
    end
    if (rx_over)
    begin
      overrun_next = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_shift_reg <= `RST_BYTE;
      overrun_reg <= 1'b0;
    end
    else
    begin
      overrun_reg <= overrun_next;
      if (rx_char_valid)
      begin
        // newest character always lands here, even when dropped
        rx_shift_reg <= rx_char_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // line status
  // ----------------------------------------------------------------
  // parity bit travels with its character, so the head decides it
  assign line_status = {5'h00,
    !fifo_empty && head_data[8],
    overrun_reg,
    !fifo_empty};

  // ----------------------------------------------------------------
  // modem inputs
  // ----------------------------------------------------------------
  // pins are asynchronous; two flops before any edge logic
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_meta_reg <= `RST_PINS;
      pin_sync_reg <= `RST_PINS;
    end
    else
    begin
      pin_meta_reg <= {dcd_n, ri_n, dsr_n, cts_n};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign pin_active = ~pin_sync_reg;
  assign loop_active = {modem_control_reg[`MC_USER_OUTPUT_TWO],
    modem_control_reg[`MC_USER_OUTPUT_ONE],
    modem_control_reg[`MC_DTR],
    modem_control_reg[`MC_RTS]};
  assign modem_active = loop_mode ? loop_active : pin_active;

  // ring flag on the trailing edge only: pin low to high
  assign change_set = {
    prev_active_reg[3] ^ modem_active[3],
    prev_active_reg[2] & ~modem_active[2],
    prev_active_reg[1] ^ modem_active[1],
    prev_active_reg[0] ^ modem_active[0]};

  always @*
  begin
    change_next = change_reg;
    if (rd_modem_status)
    begin
      change_next = 4'h0;
    end
    change_next = change_next | change_set;
  end

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_active_reg <= 4'h0;
      change_reg <= 4'h0;
    end
    else
    begin
      prev_active_reg <= modem_active;
      change_reg <= change_next;
    end
  end

  assign modem_status = {modem_active, change_reg};
  assign modem_irq = |change_reg;

  // ----------------------------------------------------------------
  // modem outputs and transmit gating
  // ----------------------------------------------------------------
  // outputs held inactive in loop-back, they are routed inside instead
  assign dtr_n = loop_mode | ~modem_control_reg[`MC_DTR];
  assign rts_n = loop_mode | ~modem_control_reg[`MC_RTS];
  assign user_output_one_n = loop_mode | ~modem_control_reg[`MC_USER_OUTPUT_ONE];
  assign user_output_two_n = loop_mode | ~modem_control_reg[`MC_USER_OUTPUT_TWO];
  // halt only gates the next start, so the running character finishes
  assign tx_halt = auto_cts_enable && !modem_active[0];
  assign tx_start_grant = tx_start_req && !tx_halt;

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  assign int_set = {4'h0, rx_push,
    rx_push && rx_char_parity_err,
    rx_over,
    |change_set};
  assign int_clr = (reg_wr && hit(reg_addr, `OFS_INT_STATUS)) ? reg_wdata : 8'h00;

  always @*
  begin
    int_status_next = sticky(int_status_reg, int_clr, int_set);
  end

  assign irq = |(int_status_reg & int_mask_reg);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fifo_ctrl_reg <= `RST_BYTE;
      modem_control_reg <= `RST_BYTE;
      enhanced_feature_control_reg <= `RST_BYTE;
      int_mask_reg <= `RST_BYTE;
      int_status_reg <= `RST_BYTE;
    end
    else
    begin
      int_status_reg <= int_status_next;
      if (reg_wr)
      begin
        case (reg_addr)
          `OFS_FIFO_CTRL:
          begin
            fifo_ctrl_reg <= reg_wdata;
          end
          `OFS_MODEM_CTRL:
          begin
            modem_control_reg <= reg_wdata;
          end
          `OFS_ENH_FEATURE:
          begin
            enhanced_feature_control_reg <= reg_wdata;
          end
          `OFS_INT_MASK:
          begin
            int_mask_reg <= reg_wdata;
          end
          default:
          begin
            int_mask_reg <= int_mask_reg;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always @*
  begin
    rdata_next = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `OFS_RX_DATA:
        begin
          rdata_next = fifo_empty ? rx_shift_reg : head_data[7:0];
        end
        `OFS_FIFO_CTRL:
        begin
          rdata_next = fifo_ctrl_reg;
        end
        `OFS_ENH_FEATURE:
        begin
          rdata_next = enhanced_feature_control_reg;
        end
        `OFS_INT_STATUS:
        begin
          rdata_next = int_status_reg;
        end
        `OFS_MODEM_CTRL:
        begin
          rdata_next = modem_control_reg;
        end
        `OFS_LINE_STATUS:
        begin
          rdata_next = line_status;
        end
        `OFS_MODEM_STATUS:
        begin
          rdata_next = modem_status;
        end
        default:
        begin
          rdata_next = int_mask_reg;
        end
      endcase
    end
  end

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_reg <= `RST_BYTE;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule // uart_line_modem_status

// File: sim/modem_peer.sv
/*
  Modem side model: drives the four active-low control pins.
  Assumes the bench names the wanted active levels in want.
*/
`timescale 1ns/1ps
module modem_peer (
  input wire ref_clk,
  input wire [3:0] want,
  output reg cts_n,
  output reg dsr_n,
  output reg ri_n,
  output reg dcd_n
);
  // ----------------------------------------
  // pins, changed just after a clock edge
  // ----------------------------------------
  initial
  begin
    {dcd_n, ri_n, dsr_n, cts_n} = 4'hF;
  end
  // clear-to-send high pauses the far transmitter
  always @(posedge ref_clk)
  begin
    {dcd_n, ri_n, dsr_n, cts_n} <= ~want;
  end
endmodule // modem_peer

// File: sim/uart_stat_properties.sv
/*
  Port assertions for the line and modem status block.
  Assumes one clock ref_clk and async active-low arst_n.
*/
`timescale 1ns/1ps
`include "uart_stat_defs.vh"
module uart_stat_checker (
  input wire ref_clk,
  input wire arst_n,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire rx_char_valid,
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire dcd_n,
  input wire tx_start_req,
  input wire tx_start_grant,
  input wire tx_halt,
  input wire modem_irq
);
  reg lb_q;
  reg ac_q;
  reg up;
  reg [3:0] pins_q;
  reg [2:0] qc;
  wire [3:0] pins = {dcd_n, ri_n, dsr_n, cts_n};
  wire ms_rd = reg_rd && reg_addr == `OFS_MODEM_STATUS;
  // ----------------------------------------
  // shadow of written modes, quiet counter
  // ----------------------------------------
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lb_q <= 1'b0;
      ac_q <= 1'b0;
      up <= 1'b0;
      pins_q <= 4'hF;
      qc <= 3'h0;
    end
    else
    begin
      up <= 1'b1;
      pins_q <= pins;
      if (reg_wr && reg_addr == `OFS_MODEM_CTRL)
        lb_q <= reg_wdata[`MC_LOOP];
      if (reg_wr && reg_addr == `OFS_ENH_FEATURE)
        ac_q <= reg_wdata[`EF_AUTO_CTS];
      // any write may enter loop-back and flag changes
      qc <= (pins != pins_q || reg_wr) ? 3'h0 : (qc == 3'h7 ? qc : qc + 3'h1);
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  // pin event, then five cycles with no register read
  sequence moved(e);
    up && !lb_q && e ##1 (!reg_rd)[*5];
  endsequence
  // character taken, no pop, then a status read one idle edge later
  sequence status_after_rx;
    rx_char_valid && !(reg_rd && reg_addr == `OFS_RX_DATA)
      ##1 !(reg_rd && reg_addr == `OFS_RX_DATA)
      ##1 reg_rd && reg_addr == `OFS_LINE_STATUS;
  endsequence
  cts_chg_a: assert property (moved($changed(cts_n)) |-> modem_irq)
    else $error("cts change not flagged");
  dsr_chg_a: assert property (moved($changed(dsr_n)) |-> modem_irq)
    else $error("dsr change not flagged");
  dcd_chg_a: assert property (moved($changed(dcd_n)) |-> modem_irq)
    else $error("carrier change not flagged");
  ring_rise_a: assert property (moved($rose(ri_n)) |-> modem_irq)
    else $error("ring rise not flagged");
  ms_read_a: assert property (ms_rd |=> ((reg_rdata[3:0] != 4'h0) == $past(modem_irq)))
    else $error("modem irq disagrees with change bits");
  clear_read_a: assert property (ms_rd && qc == 3'h7 |=> !modem_irq)
    else $error("change bits survive a read");
  hold_flags_a: assert property ($fell(modem_irq) |-> $past(ms_rd))
    else $error("change bits dropped without a read");
  grant_gate_a: assert property (tx_start_grant == (tx_start_req && !tx_halt))
    else $error("grant not gated by halt");
  halt_cts_a: assert property ((up && ac_q && !lb_q && $stable(cts_n))[*5] |-> tx_halt == cts_n)
    else $error("halt does not follow clear-to-send");
  ready_rx_a: assert property (status_after_rx |=> reg_rdata[`LS_RX_READY])
    else $error("ready flag missing after receive");
endmodule // uart_stat_checker

bind uart_line_modem_status uart_stat_checker chk_u (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .rx_char_valid(rx_char_valid),
  .cts_n(cts_n),
  .dsr_n(dsr_n),
  .ri_n(ri_n),
  .dcd_n(dcd_n),
  .tx_start_req(tx_start_req),
  .tx_start_grant(tx_start_grant),
  .tx_halt(tx_halt),
  .modem_irq(modem_irq)
);

// File: sim/tb.sv
/*
  Self-checking bench for the line and modem status block.
  Assumes the register map and field layout of uart_stat_defs.vh.
*/
`timescale 1ns/1ps
`include "uart_stat_defs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  reg ref_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, rd_pend = 0;
  reg rx_char_valid = 0, rx_char_parity_err = 0, tx_start_req = 0;
  reg [2:0] reg_addr = 0;
  reg [7:0] reg_wdata = 0, rx_char_data = 0, e, m;
  reg [3:0] want = 0;
  reg [7:0] dq [0:16];
  reg pq [0:16];
  reg [31:0] tmp;
  reg [7:0] exp_q [$], msk_q [$];
  integer seed = 30361, i, cyc = 0, n_mismatch = 0, total_checks = 0;
  wire [7:0] reg_rdata;
  wire cts_n, dsr_n, ri_n, dcd_n, rts_n, dtr_n, o1_n, o2_n, tx_start_grant, tx_halt, modem_irq, irq;
  localparam [31:0] LBX = 32'h80401020;
  uart_line_modem_status dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .rx_char_parity_err(rx_char_parity_err), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
    .dcd_n(dcd_n), .rts_n(rts_n), .dtr_n(dtr_n), .user_output_one_n(o1_n),
    .user_output_two_n(o2_n), .tx_start_req(tx_start_req), .tx_start_grant(tx_start_grant),
    .tx_halt(tx_halt), .modem_irq(modem_irq), .irq(irq));
  modem_peer peer_u (.ref_clk(ref_clk), .want(want), .cts_n(cts_n), .dsr_n(dsr_n),
    .ri_n(ri_n), .dcd_n(dcd_n));
  always #2.5 ref_clk = ~ref_clk;
  // ----------------------------------------
  // bus, receiver and pin tasks
  // ----------------------------------------
  task wr(input [2:0] a, input [7:0] d);
  begin
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [2:0] a, input [7:0] x, input [7:0] k);
  begin
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(x & k);
    msk_q.push_back(k);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  end
  endtask
  task rx(input [7:0] d, input p);
  begin
    @(posedge ref_clk);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    rx_char_parity_err <= p;
    @(posedge ref_clk);
    rx_char_valid <= 1'b0;
  end
  endtask
  // peer edge plus sync latency, rounded up
  task pins(input [3:0] w);
  begin
    want <= w;
    repeat (7) @(posedge ref_clk);
    @(negedge ref_clk);
  end
  endtask
  task summarize;
  begin
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // ----------------------------------------
  // read-data watcher and hang guard
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (rd_pend)
    begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CHK(reg_rdata & m, e)
    end
    rd_pend <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      summarize;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    wr(`OFS_LINE_STATUS, 8'hFF);
    wr(`OFS_MODEM_STATUS, 8'hFF);
    rd(`OFS_LINE_STATUS, 8'h00, 8'hFF);
    rd(`OFS_MODEM_STATUS, 8'h00, 8'hFF);
    wr(`OFS_INT_MASK, 8'h01);
    pins(4'h8);
    `CHK({modem_irq, irq}, 2'b11)
    rd(`OFS_MODEM_STATUS, 8'h88, 8'hFF);
    rd(`OFS_MODEM_STATUS, 8'h80, 8'hFF);
    @(negedge ref_clk);
    `CHK({modem_irq, irq}, 2'b01)
    wr(`OFS_INT_STATUS, 8'h01);
    wr(`OFS_INT_MASK, 8'h00);
    @(negedge ref_clk);
    `CHK(irq, 1'b0)
    // ring going active is not a ring-end edge, so no flag
    pins(4'hC);
    `CHK({modem_irq, irq}, 2'b00)
    rd(`OFS_MODEM_STATUS, 8'hC0, 8'hFF);
    pins(4'h8);
    rd(`OFS_MODEM_STATUS, 8'h84, 8'hFF);
    pins(4'hB);
    rd(`OFS_MODEM_STATUS, 8'hB3, 8'hFF);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`OFS_MODEM_CTRL, 8'h10 | (8'h01 << i));
      tmp = $random(seed);
      pins(tmp[3:0]);
      `CHK({rts_n, dtr_n, o1_n, o2_n}, 4'hF)
      rd(`OFS_MODEM_STATUS, LBX[i*8 +: 8], 8'hF0);
    end
    wr(`OFS_MODEM_CTRL, 8'h05);
    pins(4'h0);
    `CHK({o2_n, o1_n, rts_n, dtr_n}, 4'hA)
    rd(`OFS_MODEM_STATUS, 8'h00, 8'hF0);
    // clear-to-send gating, transmitter asking throughout
    wr(`OFS_ENH_FEATURE, 8'h80);
    tx_start_req <= 1'b1;
    pins(4'h0);
    `CHK({tx_halt, tx_start_grant}, 2'b10)
    pins(4'h1);
    `CHK({tx_halt, tx_start_grant}, 2'b01)
    // holding register mode: one entry
    rx(8'h5A, 1'b1);
    rd(`OFS_LINE_STATUS, 8'h05, 8'h07);
    rx(8'hC3, 1'b0);
    rd(`OFS_LINE_STATUS, 8'h07, 8'h07);
    rd(`OFS_RX_DATA, 8'h5A, 8'hFF);
    rd(`OFS_LINE_STATUS, 8'h00, 8'h03);
    rd(`OFS_RX_DATA, 8'hC3, 8'hFF);
    // fifo mode: fill past sixteen, drain all
    wr(`OFS_FIFO_CTRL, 8'h01);
    for (i = 0; i < 17; i = i + 1)
    begin
      tmp = $random(seed);
      dq[i] = tmp[7:0];
      pq[i] = tmp[8];
      rx(dq[i], pq[i]);
    end
    rd(`OFS_LINE_STATUS, {5'h00, pq[0], 2'b11}, 8'h07);
    for (i = 0; i < 16; i = i + 1)
    begin
      rd(`OFS_LINE_STATUS, {5'h00, pq[i], 2'b01}, 8'h07);
      rd(`OFS_RX_DATA, dq[i], 8'hFF);
    end
    rd(`OFS_LINE_STATUS, 8'h00, 8'h01);
    repeat (3) @(posedge ref_clk);
    summarize;
  end
endmodule // tb
